// >>> rtl/frp_pkg.sv
// Package: register map, field positions, timing and state types of the flash row sequencer
package frp_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [7:0] OFS_DATA_LO = 8'h10;
  localparam logic [7:0] OFS_DATA_HI = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  // Control register field positions
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_WRITE_PERMIT = 2;
  localparam int CTL_ERR = 3;
  localparam int CTL_FREE = 4;
  localparam int CTL_LATCH_LOAD_ONLY = 5;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_FIXED = 7;
  // Interrupt status field positions
  localparam int IRQ_ERASE = 0;
  localparam int IRQ_PROG = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_SEQERR = 3;
  localparam int IRQ_W = 4;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Geometry
  localparam int NUM_LATCH = 32;
  localparam int COL_W = 5;
  localparam int ROW_W = 10;
  localparam int WORD_W = 14;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_CYCLES = 2;
  localparam int ERASE_TIME_MS = 2;
  localparam int PROG_TIME_MS = 2;
  localparam int ERASE_CYCLES_DEF = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  // State types
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} frp_key_e;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_SETUP, SEQ_ERASE, SEQ_STREAM, SEQ_PWAIT} frp_seq_e;
  // Row number from the address pair
  function automatic logic [ROW_W-1:0] frp_row(input logic [6:0] hi, input logic [7:0] lo);
    frp_row = {hi, lo[7:5]};
  endfunction
endpackage

// >>> rtl/frp_latch_bank.sv
// Write latch bank: one row of word latches, blank after clear
`timescale 1ns/1ps
`default_nettype none
module frp_latch_bank
  import frp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Load port
  input wire logic load_en,
  input wire logic [COL_W-1:0] load_idx,
  input wire logic [WORD_W-1:0] load_data,
  // Clear to blank
  input wire logic clear_all,
  // Read port
  input wire logic [COL_W-1:0] rd_idx,
  output logic [WORD_W-1:0] rd_data
);
  logic [WORD_W-1:0] mem_reg [NUM_LATCH];
  logic [WORD_W-1:0] mem_next [NUM_LATCH];

  // Next latch contents; clear wins since it ends an operation
  always_comb begin
    for (int i = 0; i < NUM_LATCH; i++) begin
      mem_next[i] = mem_reg[i];
      if (clear_all) begin
        mem_next[i] = BLANK_WORD; // RULE9
      end else if (load_en && load_idx == COL_W'(i)) begin
        mem_next[i] = load_data;
      end
    end
  end

  // Latch storage
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_LATCH; i++) begin
        mem_reg[i] <= BLANK_WORD;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rd_data = mem_reg[rd_idx];

  property p_blank_after_clear;
    @(posedge mclk) disable iff (sys_rst)
    clear_all |=> (mem_reg[0] == BLANK_WORD && mem_reg[NUM_LATCH-1] == BLANK_WORD);
  endproperty
  a_blank_after_clear: assert property (p_blank_after_clear) else $error("latches not blank"); // RULE9

  property p_load_stores;
    @(posedge mclk) disable iff (sys_rst)
    load_en && !clear_all |=> mem_reg[$past(load_idx)] == $past(load_data);
  endproperty
  a_load_stores: assert property (p_load_stores) else $error("latch load lost"); // RULE10
endmodule
`default_nettype wire

// >>> rtl/frp_sequencer.sv
// Flash row erase and program sequencer with AHB-Lite register slave
// Behaviour
// RULE1 - Flash is erased only as a whole row, never word by word.
// RULE2 - Software loads address, clears config select, sets erase and permit, unlocks, starts.
// RULE3 - Two forced no_operation cycles follow the write start set.
// RULE4 - Erase stalls the processor about 2 ms; clocks and peripherals keep running.
// RULE5 - After erase or program, execution resumes right after the two forced cycles.
// RULE6 - Programming never erases automatically; words must already be blank.
// RULE7 - One program operation writes up to all 32 latches.
// RULE8 - Upper ten address bits pick the row, low five the latch; no row crossing.
// RULE9 - Every write or erase ends with all latches blank, 0x3FFF.
// RULE10 - Latch-load-only start loads just the addressed latch, no flash write.
// RULE11 - Normal start loads the addressed latch then programs the whole row.
// RULE12 - Broken unlock sequence loads no latch and starts no programming.
// RULE13 - Software loads words with latch_load_only set, clears it before the last.
// RULE14 - Write and read start are set-only; hardware clears them when done.
// RULE15 - A reset during a write sets the program error flag.
// RULE16 - Latch-load-only forces two no_operation cycles, then continues without stall.
// RULE17 - Hardware clears erase select once the erase completes.
// RULE18 - Without write permit a start does nothing to flash or latches.
// RULE19 - Software masks global interrupts around the unlock sequence.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module frp_sequencer
  import frp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor control
  output logic cpu_nop,
  output logic cpu_stall,
  // Flash array
  output logic fl_erase,
  output logic fl_prog,
  output logic [ROW_W-1:0] fl_row,
  output logic [COL_W-1:0] fl_col,
  output logic [WORD_W-1:0] fl_wdata,
  output logic fl_wstrobe,
  // Interrupt
  output logic irq
);
  // Bus state
  logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next, hready_reg, hready_next;
  logic [7:0] baddr_reg, baddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  // Register and sequencer state
  logic config_space_select_reg, config_space_select_next, latch_load_only_reg, latch_load_only_next, free_reg, free_next;
  logic write_permit_reg, write_permit_next, wr_reg, wr_next, rd_reg, rd_next;
  logic [7:0] alo_reg, alo_next, dlo_reg, dlo_next;
  logic [6:0] ahi_reg, ahi_next;
  logic [5:0] dhi_reg, dhi_next;
  logic [IRQ_W-1:0] st_reg, st_next, en_reg, en_next;
  frp_key_e key_reg, key_next;
  frp_seq_e seq_reg, seq_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic op_erase_reg, op_erase_next, op_prog_reg, op_prog_next;
  logic nop_reg, stall_reg, erase_reg, prog_reg, strobe_reg, irq_reg;
  logic strobe_next;
  logic [ROW_W-1:0] row_reg, row_next;
  logic [COL_W-1:0] fcol_reg, fcol_next;
  logic [WORD_W-1:0] wdata_reg, wdata_next;
  // Error flag kept across device reset
  logic err_reg, err_next, inflight_reg, inflight_next;
  // Decoded events
  logic bus_acc, wr_now, ctl_wr, start_req, ok_start, rejected, lat_we, lat_clr;
  logic done_now, setup_end, op_end;
  logic [WORD_W-1:0] lat_rd;

  // Write lands in the data phase; address phase decode for both directions
  assign bus_acc = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
  assign wr_now = wr_pend_reg;
  assign ctl_wr = wr_now && baddr_reg == OFS_CTRL && seq_reg == SEQ_IDLE;
  assign start_req = ctl_wr && hwdata[CTL_WR] && !wr_reg;
  // Start needs a completed unlock, write permit and program space
  assign ok_start = start_req && key_reg == KEY_ARMED && hwdata[CTL_WRITE_PERMIT] // RULE12 RULE18
    && !hwdata[CTL_CONFIG_SPACE_SELECT];
  assign rejected = start_req && !ok_start;
  assign lat_we = ok_start && !hwdata[CTL_FREE]; // RULE10 RULE11
  assign setup_end = seq_reg == SEQ_SETUP && cnt_reg == 32'(SETUP_CYCLES - 1);
  assign done_now = (seq_reg == SEQ_ERASE && cnt_reg == 32'(ERASE_CYCLES - 1))
    || (seq_reg == SEQ_PWAIT && cnt_reg == 32'(PROG_CYCLES - 1));
  assign op_end = done_now || (setup_end && !op_erase_reg && !op_prog_reg);
  assign lat_clr = done_now; // RULE9

  frp_latch_bank u_latch (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load_en(lat_we),
    .load_idx(alo_reg[COL_W-1:0]), // RULE8
    .load_data({dhi_reg, dlo_reg}),
    .clear_all(lat_clr),
    .rd_idx(col_reg),
    .rd_data(lat_rd)
  );

  // Bus slave: writes zero wait, reads one wait so data comes from a flop
  always_comb begin
    wr_pend_next = bus_acc && hwrite;
    rd_pend_next = bus_acc && !hwrite;
    baddr_next = bus_acc ? haddr[7:0] : baddr_reg;
    hready_next = !rd_pend_next;
    hrdata_next = hrdata_reg;
    if (rd_pend_reg) begin
      unique case (baddr_reg)
        OFS_CTRL: hrdata_next = {24'h000000, 1'b1, config_space_select_reg, latch_load_only_reg, free_reg, err_reg,
                                 write_permit_reg, wr_reg, rd_reg};
        OFS_ADDR_LO: hrdata_next = {24'h000000, alo_reg};
        OFS_ADDR_HI: hrdata_next = {24'h000000, 1'b1, ahi_reg};
        OFS_DATA_LO: hrdata_next = {24'h000000, dlo_reg};
        OFS_DATA_HI: hrdata_next = {26'h0000000, dhi_reg};
        OFS_IRQ_STAT: hrdata_next = {28'h0000000, st_reg};
        OFS_IRQ_EN: hrdata_next = {28'h0000000, en_reg};
        default: hrdata_next = 32'h00000000; // Key, clear and unmapped read zero
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hready_reg <= 1'b1;
      baddr_reg <= RST_BYTE;
      hrdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      hready_reg <= hready_next;
      baddr_reg <= baddr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Registers, unlock tracking and the operation sequence
  always_comb begin
    config_space_select_next = config_space_select_reg;
    latch_load_only_next = latch_load_only_reg;
    free_next = free_reg;
    write_permit_next = write_permit_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    alo_next = alo_reg;
    ahi_next = ahi_reg;
    dlo_next = dlo_reg;
    dhi_next = dhi_reg;
    en_next = en_reg;
    st_next = st_reg;
    key_next = key_reg;
    seq_next = seq_reg;
    cnt_next = cnt_reg + 32'h00000001;
    col_next = col_reg;
    op_erase_next = op_erase_reg;
    op_prog_next = op_prog_reg;
    row_next = row_reg;
    fcol_next = fcol_reg;
    wdata_next = wdata_reg;
    strobe_next = 1'b0;
    // Any other register write between the keys breaks the unlock
    if (wr_now) begin
      if (baddr_reg == OFS_KEY && hwdata[7:0] == KEY_FIRST) begin
        key_next = KEY_HALF;
      end else if (baddr_reg == OFS_KEY && hwdata[7:0] == KEY_SECOND && key_reg == KEY_HALF) begin
        key_next = KEY_ARMED;
      end else begin
        key_next = KEY_IDLE; // RULE12
      end
      unique case (baddr_reg)
        OFS_ADDR_LO: alo_next = hwdata[7:0];
        OFS_ADDR_HI: ahi_next = hwdata[6:0];
        OFS_DATA_LO: dlo_next = hwdata[7:0];
        OFS_DATA_HI: dhi_next = hwdata[5:0];
        OFS_IRQ_EN: en_next = hwdata[IRQ_W-1:0];
        OFS_IRQ_CLR: st_next = st_reg & ~hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Control bits; read start can only be set here, write start only by ok_start in idle
    if (ctl_wr) begin
      config_space_select_next = hwdata[CTL_CONFIG_SPACE_SELECT];
      latch_load_only_next = hwdata[CTL_LATCH_LOAD_ONLY];
      free_next = hwdata[CTL_FREE];
      write_permit_next = hwdata[CTL_WRITE_PERMIT];
      rd_next = rd_reg | (hwdata[CTL_RD] & !hwdata[CTL_WR]); // RULE14
    end
    unique case (seq_reg)
      SEQ_IDLE: begin
        cnt_next = 32'h00000000;
        if (ok_start || (ctl_wr && hwdata[CTL_RD] && !hwdata[CTL_WR])) begin
          seq_next = SEQ_SETUP; // RULE3
          wr_next = ok_start;
          op_erase_next = ok_start && hwdata[CTL_FREE];
          op_prog_next = ok_start && !hwdata[CTL_FREE] && !hwdata[CTL_LATCH_LOAD_ONLY]; // RULE6
          row_next = frp_row(ahi_reg, alo_reg); // RULE8
        end
      end
      SEQ_SETUP: begin
        if (setup_end) begin
          cnt_next = 32'h00000000;
          col_next = '0;
          if (op_erase_reg) begin
            seq_next = SEQ_ERASE; // RULE1 RULE4
          end else if (op_prog_reg) begin
            seq_next = SEQ_STREAM;
          end else begin
            seq_next = SEQ_IDLE; // RULE16
            wr_next = 1'b0;
            rd_next = 1'b0;
            st_next[IRQ_LOAD] = st_next[IRQ_LOAD] | wr_reg; // Sticky; a read start keeps it
          end
        end
      end
      SEQ_STREAM: begin
        // One latch per cycle out to the array; the row never changes here
        strobe_next = 1'b1; // RULE7
        fcol_next = col_reg;
        wdata_next = lat_rd;
        col_next = col_reg + 5'h01;
        cnt_next = 32'h00000000;
        if (col_reg == 5'(NUM_LATCH - 1)) begin
          seq_next = SEQ_PWAIT;
        end
      end
      SEQ_ERASE, SEQ_PWAIT: begin
        if (done_now) begin
          seq_next = SEQ_IDLE; // RULE5
          wr_next = 1'b0; // RULE14
          if (seq_reg == SEQ_ERASE) begin
            free_next = 1'b0; // RULE17
            st_next[IRQ_ERASE] = 1'b1;
          end else begin
            st_next[IRQ_PROG] = 1'b1;
          end
          op_erase_next = 1'b0;
          op_prog_next = 1'b0;
        end
      end
      default: seq_next = SEQ_IDLE; // Illegal code falls back to idle
    endcase
    // Sticky events win over a clear in the same cycle
    if (rejected) begin
      st_next[IRQ_SEQERR] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      config_space_select_reg <= 1'b0;
      latch_load_only_reg <= 1'b0;
      free_reg <= 1'b0;
      write_permit_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      alo_reg <= RST_BYTE;
      ahi_reg <= 7'h00;
      dlo_reg <= RST_BYTE;
      dhi_reg <= 6'h00;
      en_reg <= RST_IRQ;
      st_reg <= RST_IRQ;
      key_reg <= KEY_IDLE;
      seq_reg <= SEQ_IDLE;
      cnt_reg <= 32'h00000000;
      col_reg <= '0;
      op_erase_reg <= 1'b0;
      op_prog_reg <= 1'b0;
      row_reg <= '0;
      fcol_reg <= '0;
      wdata_reg <= BLANK_WORD;
      strobe_reg <= 1'b0;
      nop_reg <= 1'b0;
      stall_reg <= 1'b0;
      erase_reg <= 1'b0;
      prog_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      config_space_select_reg <= config_space_select_next;
      latch_load_only_reg <= latch_load_only_next;
      free_reg <= free_next;
      write_permit_reg <= write_permit_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      alo_reg <= alo_next;
      ahi_reg <= ahi_next;
      dlo_reg <= dlo_next;
      dhi_reg <= dhi_next;
      en_reg <= en_next;
      st_reg <= st_next;
      key_reg <= key_next;
      seq_reg <= seq_next;
      cnt_reg <= cnt_next;
      col_reg <= col_next;
      op_erase_reg <= op_erase_next;
      op_prog_reg <= op_prog_next;
      row_reg <= row_next;
      fcol_reg <= fcol_next;
      wdata_reg <= wdata_next;
      strobe_reg <= strobe_next;
      nop_reg <= seq_next == SEQ_SETUP; // RULE3 RULE16
      stall_reg <= seq_next inside {SEQ_ERASE, SEQ_STREAM, SEQ_PWAIT}; // RULE4
      erase_reg <= seq_next == SEQ_ERASE;
      prog_reg <= seq_next inside {SEQ_STREAM, SEQ_PWAIT};
      irq_reg <= |(st_next & en_next);
    end
  end

  // Error flag lives on power-on reset only, so a device reset cannot hide it
  always_comb begin
    err_next = err_reg;
    inflight_next = inflight_reg;
    if (sys_rst) begin
      if (inflight_reg) begin
        err_next = 1'b1; // RULE15
        inflight_next = 1'b0;
      end
    end else begin
      if (ctl_wr) begin
        err_next = hwdata[CTL_ERR];
      end
      if (rejected) begin
        err_next = 1'b1;
      end
      if (ok_start && (hwdata[CTL_FREE] || !hwdata[CTL_LATCH_LOAD_ONLY])) begin
        inflight_next = 1'b1;
      end else if (done_now) begin
        inflight_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge por_rst) begin
    if (por_rst) begin
      err_reg <= 1'b0;
      inflight_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
      inflight_reg <= inflight_next;
    end
  end

  // Outputs straight from flops; hresp is tied low
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign cpu_nop = nop_reg;
  assign cpu_stall = stall_reg;
  assign fl_erase = erase_reg;
  assign fl_prog = prog_reg;
  assign fl_row = row_reg;
  assign fl_col = fcol_reg;
  assign fl_wdata = wdata_reg;
  assign fl_wstrobe = strobe_reg;
  assign irq = irq_reg;

  sequence s_nops;
    nop_reg [*2] ##1 !nop_reg;
  endsequence
  sequence s_quiet;
    (!stall_reg && !prog_reg && !erase_reg) [*3];
  endsequence

  property p_nop_pair;
    @(posedge mclk) disable iff (sys_rst) ok_start |=> s_nops;
  endproperty
  a_nop_pair: assert property (p_nop_pair) else $error("forced cycles wrong"); // RULE3
  property p_load_only;
    @(posedge mclk) disable iff (sys_rst)
    ok_start && hwdata[CTL_LATCH_LOAD_ONLY] && !hwdata[CTL_FREE] |=> s_quiet;
  endproperty
  a_load_only: assert property (p_load_only) else $error("load only stalled"); // RULE10 RULE16
  property p_erase_stall;
    @(posedge mclk) disable iff (sys_rst)
    ok_start && hwdata[CTL_FREE] |=> ##2 (erase_reg && stall_reg && !nop_reg);
  endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("erase stall missing"); // RULE4
  property p_prog_start;
    @(posedge mclk) disable iff (sys_rst)
    ok_start && !hwdata[CTL_LATCH_LOAD_ONLY] && !hwdata[CTL_FREE] |=> ##2 (prog_reg && stall_reg)
      ##1 (strobe_reg && fl_col == 5'h00);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program not started"); // RULE11
  property p_rows_only;
    @(posedge mclk) disable iff (sys_rst) erase_reg |-> !strobe_reg && !prog_reg;
  endproperty
  a_rows_only: assert property (p_rows_only) else $error("erase mixed with writes"); // RULE1 RULE6
  property p_row_fixed;
    @(posedge mclk) disable iff (sys_rst)
    strobe_reg && $past(strobe_reg) |-> $stable(fl_row) && fl_col == $past(fl_col) + 5'h01;
  endproperty
  a_row_fixed: assert property (p_row_fixed) else $error("row crossed"); // RULE8 RULE7
  property p_locked;
    @(posedge mclk) disable iff (sys_rst)
    lat_we |-> key_reg == KEY_ARMED && wr_now && baddr_reg == OFS_CTRL;
  endproperty
  a_locked: assert property (p_locked) else $error("latch loaded unlocked"); // RULE12
  property p_permit;
    @(posedge mclk) disable iff (sys_rst)
    start_req && !hwdata[CTL_WRITE_PERMIT] |=> (seq_reg == SEQ_IDLE && !wr_reg) [*3];
  endproperty
  a_permit: assert property (p_permit) else $error("start without permit"); // RULE18
  property p_wr_clear;
    @(posedge mclk) disable iff (sys_rst) $fell(wr_reg) |-> $past(op_end);
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("start bit cleared early"); // RULE14
  property p_free_clear;
    @(posedge mclk) disable iff (sys_rst) done_now && seq_reg == SEQ_ERASE |=> !free_reg;
  endproperty
  a_free_clear: assert property (p_free_clear) else $error("erase select kept"); // RULE17
  property p_resume;
    @(posedge mclk) disable iff (sys_rst) $fell(stall_reg) |-> !nop_reg && seq_reg == SEQ_IDLE;
  endproperty
  a_resume: assert property (p_resume) else $error("resume wrong"); // RULE5
  property p_reset_err;
    @(posedge mclk) disable iff (por_rst) sys_rst && inflight_reg |=> err_reg;
  endproperty
  a_reset_err: assert property (p_reset_err) else $error("reset error not flagged"); // RULE15
endmodule
`default_nettype wire

// >>> test/flash_row_erase_and_program_test.sv
// Testbench: flash row sequencer driven over its bus, checked against a bench model
`timescale 1ns/1ps
`default_nettype none
module flash_row_erase_and_program_test;
  import frp_pkg::*;
  localparam int EC = 20;
  localparam int PC = 20;
  localparam logic [9:0] ROW = 10'h2b5;
  logic mclk, sys_rst, por_rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rv, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic cpu_nop, cpu_stall, fl_erase, fl_prog, fl_wstrobe;
  logic [ROW_W-1:0] fl_row, rq;
  logic [COL_W-1:0] fl_col;
  logic [WORD_W-1:0] fl_wdata;
  logic [WORD_W-1:0] lat [NUM_LATCH];
  logic [WORD_W-1:0] wq [$];
  logic [COL_W-1:0] cq [$];
  int fails, checked, ne, n, np;
  // Single slave, so its own ready closes the loop
  assign hready = hreadyout;
  frp_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .por_rst(por_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_nop(cpu_nop),
    .cpu_stall(cpu_stall), .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_row(fl_row),
    .fl_col(fl_col), .fl_wdata(fl_wdata), .fl_wstrobe(fl_wstrobe), .irq(irq));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // What the flash array sees: strobed words and erase length
  always @(posedge mclk) begin
    if (fl_wstrobe === 1'b1) begin
      wq.push_back(fl_wdata);
      cq.push_back(fl_col);
      rq = fl_row;
    end
    if (fl_prog === 1'b1) begin
      np++;
    end
    if (fl_erase === 1'b1) begin
      ne++;
      rq = fl_row;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single word transfer; waits on ready, never on a cycle count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rv);
    chk(nm, rv, e);
  endtask
  task automatic ul(input logic [7:0] c);
    xfer(1'b1, OFS_KEY, {24'h0, KEY_FIRST}, rv);
    xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND}, rv);
    xfer(1'b1, OFS_CTRL, {24'h0, c}, rv);
  endtask
  // Unlock and start, then count stalled cycles after the two forced ones
  task automatic run(input logic [7:0] c, input logic ok);
    ul(c);
    @(posedge mclk);
    chk("nop_first", cpu_nop, {31'h0, ok});
    @(posedge mclk);
    chk("nop_second", cpu_nop, {31'h0, ok});
    n = 0;
    @(posedge mclk);
    while (cpu_stall === 1'b1 && n < 5000) begin
      n++;
      @(posedge mclk);
    end
  endtask
  task automatic ld(input logic [4:0] col, input logic [13:0] d, input logic [7:0] c);
    xfer(1'b1, OFS_ADDR_LO, {24'h0, ROW[2:0], col}, rv);
    xfer(1'b1, OFS_DATA_LO, {24'h0, d[7:0]}, rv);
    xfer(1'b1, OFS_DATA_HI, {26'h0, d[13:8]}, rv);
    run(c, 1'b1);
    lat[col] = d;
  endtask
  // Whole row must reach flash in column order, then the model goes blank
  task automatic row_chk();
    chk("prog_stall", n, 32 + PC);
    chk("prog_len", np, 32 + PC);
    np = 0;
    chk("strobes", wq.size(), 32);
    chk("prog_row", rq, ROW);
    for (int i = 0; i < 32; i++) begin
      chk("word", wq[i], lat[i]);
      chk("col", cq[i], i);
      lat[i] = BLANK_WORD;
    end
    wq.delete();
    cq.delete();
    rc("ctrl_prog", OFS_CTRL, 32'h84);
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #300000;
    fails++;
    close_out();
  end
  // Main sequence
  initial begin
    logic [4:0] c;
    {sys_rst, por_rst, hsel, hwrite, htrans, haddr, hwdata} = {4'hc, 66'h0};
    hsize = HSIZE_WORD;
    {fails, checked, ne, np} = '0;
    seed = 32'h6192c560;
    foreach (lat[i]) lat[i] = BLANK_WORD;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    rc("ctrl_rst", OFS_CTRL, 32'h80);
    rc("addr_hi_rst", OFS_ADDR_HI, 32'h80);
    rc("key_read", OFS_KEY, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    chk("hresp", hresp, 0);
    xfer(1'b1, OFS_IRQ_EN, 32'hf, rv);
    xfer(1'b1, OFS_ADDR_HI, {25'h0, ROW[9:3]}, rv);
    xfer(1'b1, OFS_CTRL, 32'h24, rv);
    ld(5'd9, 14'h0123, 8'h26);
    chk("load_stall", n, 0);
    chk("load_no_write", wq.size(), 0);
    xfer(1'b1, OFS_CTRL, 32'h14, rv);
    ne = 0;
    run(8'h16, 1'b1);
    chk("erase_len", ne, EC);
    chk("erase_stall", n, EC);
    chk("erase_row", rq, ROW);
    lat[9] = BLANK_WORD;
    rc("ctrl_erase", OFS_CTRL, 32'h84);
    xfer(1'b1, OFS_IRQ_EN, 32'h0, rv);
    rc("stat_erase", OFS_IRQ_STAT, 32'h5);
    chk("irq_masked", irq, 0);
    xfer(1'b1, OFS_IRQ_EN, 32'hf, rv);
    rc("stat_keep", OFS_IRQ_STAT, 32'h5);
    chk("irq_on", irq, 1);
    xfer(1'b1, OFS_IRQ_CLR, 32'hf, rv);
    rc("stat_clr", OFS_IRQ_STAT, 32'h0);
    chk("irq_off", irq, 0);
    // Broken unlock: a data write between the two keys
    xfer(1'b1, OFS_KEY, {24'h0, KEY_FIRST}, rv);
    xfer(1'b1, OFS_DATA_LO, 32'h3c, rv);
    xfer(1'b1, OFS_KEY, {24'h0, KEY_SECOND}, rv);
    xfer(1'b1, OFS_CTRL, 32'h26, rv);
    rc("stat_broken", OFS_IRQ_STAT, 32'h8);
    rc("ctrl_broken", OFS_CTRL, 32'hac);
    xfer(1'b1, OFS_CTRL, 32'h20, rv);
    run(8'h22, 1'b0);
    rc("ctrl_no_permit", OFS_CTRL, 32'ha8);
    xfer(1'b1, OFS_CTRL, 32'h24, rv);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : seed[4:0];
      ld(c, seed[18:5], 8'h26);
    end
    seed = lfsr(seed);
    ld(5'd17, seed[13:0], 8'h06);
    row_chk();
    xfer(1'b1, OFS_CTRL, 32'h04, rv);
    ld(5'd5, 14'h2a5a, 8'h06);
    row_chk();
    // Read start only forces the two cycles and leaves sticky bits alone
    run(8'h05, 1'b1);
    rc("ctrl_read", OFS_CTRL, 32'h84);
    rc("stat_read", OFS_IRQ_STAT, 32'he);
    // Reset in mid-erase must leave the error flag behind
    xfer(1'b1, OFS_CTRL, 32'h14, rv);
    ul(8'h16);
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    rc("ctrl_reset_err", OFS_CTRL, 32'h88);
    close_out();
  end
endmodule
`default_nettype wire
